// file: inc/crs_pkg.sv
// Package for the core register set: offsets, flag positions, op codes
package crs_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_RESULT  = 8'h00;
  localparam logic [7:0] OFF_OFS1    = 8'h04;
  localparam logic [7:0] OFF_OFS2    = 8'h08;
  localparam logic [7:0] OFF_FRAME   = 8'h0c;
  localparam logic [7:0] OFF_FETCH   = 8'h10;
  localparam logic [7:0] OFF_COND    = 8'h14;
  localparam logic [7:0] OFF_CTRL    = 8'h18;
  localparam logic [7:0] OFF_OP      = 8'h1c;
  localparam logic [7:0] OFF_STATUS  = 8'h20;

  // Flag positions
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_I = 2;
  localparam int FLG_D = 3;
  localparam int FLG_B = 4;
  localparam int FLG_T = 5;
  localparam int FLG_V = 6;
  localparam int FLG_N = 7;

  // Control register field
  localparam int CTRL_PAGE = 0;

  // Reset values, stack page bytes and bus error word
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [7:0]  RST_FRAME = 8'hff;
  localparam logic [15:0] RST_FETCH = 16'h0000;
  localparam logic [7:0]  RST_COND  = 8'h04;
  localparam logic [7:0]  PAGE_ZERO = 8'h00;
  localparam logic [7:0]  PAGE_ONE  = 8'h01;
  localparam logic [31:0] BUS_ERR   = 32'hdeadbeef;

  // Operation codes written to the op register
  typedef enum logic [4:0] {
    OP_NONE       = 5'h00,
    OP_SET_CARRY  = 5'h01,
    OP_CLR_CARRY  = 5'h02,
    OP_MASK_IRQ   = 5'h03,
    OP_UNMASK_IRQ = 5'h04,
    OP_DEC_ON     = 5'h05,
    OP_DEC_OFF    = 5'h06,
    OP_SETT       = 5'h07,
    OP_DIRECT_OFF = 5'h08,
    OP_OVF_RESET  = 5'h09,
    OP_PUSH_WORK  = 5'h0a,
    OP_POP_WORK   = 5'h0b,
    OP_PUSH_P     = 5'h0c,
    OP_POP_P      = 5'h0d,
    OP_SOFT_BREAK = 5'h0e,
    OP_ADD     = 5'h0f,
    OP_SUB     = 5'h10,
    OP_BIT     = 5'h11,
    OP_LOAD    = 5'h12,
    OP_SHL     = 5'h13,
    OP_ROR     = 5'h14,
    OP_FAST_SPEED = 5'h15,
    OP_LOW_SPEED  = 5'h16
  } crs_op_t;

  // Stack memory request toward the core's data memory
  typedef struct packed {
    logic        push;
    logic        pop;
    logic [15:0] addr;
    logic [7:0]  data;
  } crs_stack_t;

endpackage

// file: logic/crs_core_regs.sv
// Core register set with condition word, stack addressing and ops
//
// How it works
// RULE_01 - Eight-bit working register carries data operations
// RULE_02 - First offset register forms indexed addresses
// RULE_03 - Second offset register forms indexed addresses
// RULE_04 - Frame pointer gives stack address low byte
// RULE_05 - Page bit selects stack high byte
// RULE_06 - Sixteen-bit fetch pointer from two halves
// RULE_07 - Condition word: five status, three control flags
// RULE_08 - Branch tests on carry, zero, overflow, negative
// RULE_09 - Decimal mode leaves zero, overflow, negative invalid
// RULE_10 - Bit 0 takes carry, shifts, rotates
// RULE_11 - Bit 1 set on zero result
// RULE_12 - Bit 2 masks all but break
// RULE_13 - Bit 3 selects binary or decimal arithmetic
// RULE_14 - Bit 4 reads zero, pushed one on break
// RULE_15 - Bit 5 enables memory to memory operation
// RULE_16 - Bit 6 set on signed overflow
// RULE_17 - Bit 7 set on negative result
// RULE_18 - Bit test copies memory bits 6, 7
// RULE_19 - Set and clear ops per listed flags
// RULE_20 - Push and pop working register, condition word
// RULE_21 - Speed ops refused, others supported
// RULE_22 - Push post-decrements, pop pre-increments frame pointer
`timescale 1ns/1ps

module crs_core_regs (
  // Clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_reset,
  // Wishbone slave
  input  wire logic                i_wb_cyc,
  input  wire logic                i_wb_stb,
  input  wire logic                i_wb_we,
  input  wire logic [7:0]          i_wb_adr,
  input  wire logic [3:0]          i_wb_sel,
  input  wire logic [31:0]         i_wb_dat,
  output logic      [31:0]         o_wb_dat,
  output logic                     o_wb_ack,
  output logic                     o_wb_err,
  // Memory operand and stack return data
  input  wire logic [7:0]          i_mem_data,
  input  wire logic [7:0]          i_pop_data,
  // Stack request and core status
  output crs_pkg::crs_stack_t      o_stack,
  output logic      [15:0]         o_stack_addr,
  output logic                     o_irq_masked,
  output logic                     o_decimal,
  output logic                     o_direct_mem,
  output logic      [3:0]          o_branch_cond,
  output logic                     o_op_refused
);

  // Architectural state
  logic [7:0]  result_r;
  logic [7:0]  ofs1_r;
  logic [7:0]  ofs2_r;
  logic [7:0]  frame_r;
  logic [7:0]  fetch_hi_r;
  logic [7:0]  fetch_lo_r;
  logic [7:0]  cond_r;
  logic        page_r;
  logic        refused_r;
  logic        ack_r;
  logic        err_r;
  logic [31:0] rdat_r;
  logic        pop_pend_r;
  logic        pop_cond_r;
  crs_pkg::crs_stack_t stack_r;

  // Bus decode
  wire         req     = i_wb_cyc & i_wb_stb & ~ack_r & ~err_r;
  wire         wr      = req & i_wb_we;
  wire         hit_res = i_wb_adr == crs_pkg::OFF_RESULT;
  wire         hit_o1  = i_wb_adr == crs_pkg::OFF_OFS1;
  wire         hit_o2  = i_wb_adr == crs_pkg::OFF_OFS2;
  wire         hit_fr  = i_wb_adr == crs_pkg::OFF_FRAME;
  wire         hit_fp  = i_wb_adr == crs_pkg::OFF_FETCH;
  wire         hit_cw  = i_wb_adr == crs_pkg::OFF_COND;
  wire         hit_ct  = i_wb_adr == crs_pkg::OFF_CTRL;
  wire         hit_op  = i_wb_adr == crs_pkg::OFF_OP;
  wire         hit_st  = i_wb_adr == crs_pkg::OFF_STATUS;
  wire         mapped  = hit_res | hit_o1 | hit_o2 | hit_fr | hit_fp |
                         hit_cw | hit_ct | hit_op | hit_st;
  wire         b0      = i_wb_sel[0];
  wire         b1      = i_wb_sel[1];

  // Operation issued by a write to the op register
  wire                 op_go = wr & hit_op & b0;
  crs_pkg::crs_op_t    op;
  assign op = op_go ? crs_pkg::crs_op_t'(i_wb_dat[4:0]) : crs_pkg::OP_NONE;

  // Stack address: page byte above frame pointer
  wire [7:0]  page_hi = page_r ? crs_pkg::PAGE_ONE
                               : crs_pkg::PAGE_ZERO; // RULE_05
  wire [15:0] stk_now = {page_hi, frame_r};          // RULE_04
  wire [7:0]  frame_inc = frame_r + 8'h01;
  wire [15:0] stk_pop = {page_hi, frame_inc};        // RULE_22

  // Arithmetic: operand from memory, binary or decimal adjust
  wire [8:0] bin_add = {1'b0, result_r} + {1'b0, i_mem_data}
                       + {8'h00, cond_r[crs_pkg::FLG_C]};
  wire [8:0] bin_sub = {1'b0, result_r} - {1'b0, i_mem_data}
                       - {8'h00, ~cond_r[crs_pkg::FLG_C]};
  wire [4:0] lo_add  = {1'b0, result_r[3:0]} + {1'b0, i_mem_data[3:0]}
                       + {4'h0, cond_r[crs_pkg::FLG_C]};
  wire       lo_cy   = lo_add > 5'd9;
  wire [4:0] lo_fix  = lo_cy ? lo_add + 5'd6 : lo_add;
  wire [4:0] hi_add  = {1'b0, result_r[7:4]} + {1'b0, i_mem_data[7:4]}
                       + {4'h0, lo_cy};
  wire       hi_cy   = hi_add > 5'd9;
  wire [4:0] hi_fix  = hi_cy ? hi_add + 5'd6 : hi_add;
  wire [8:0] dec_add = {hi_cy, hi_fix[3:0], lo_fix[3:0]};
  wire [4:0] lo_sub  = {1'b0, result_r[3:0]} - {1'b0, i_mem_data[3:0]}
                       - {4'h0, ~cond_r[crs_pkg::FLG_C]};
  wire       lo_bw   = lo_sub[4];
  wire [4:0] lo_sfx  = lo_bw ? lo_sub - 5'd6 : lo_sub;
  wire [4:0] hi_sub  = {1'b0, result_r[7:4]} - {1'b0, i_mem_data[7:4]}
                       - {4'h0, lo_bw};
  wire       hi_bw   = hi_sub[4];
  wire [4:0] hi_sfx  = hi_bw ? hi_sub - 5'd6 : hi_sub;
  wire [8:0] dec_sub = {~hi_bw, hi_sfx[3:0], lo_sfx[3:0]};
  wire       dec     = cond_r[crs_pkg::FLG_D];
  wire [8:0] sum_add = dec ? dec_add : bin_add;      // RULE_13
  // Carry after a subtract means no borrow, the same sense as carry in
  wire [8:0] bin_sbc = {~bin_sub[8], bin_sub[7:0]};  // RULE_10
  wire [8:0] sum_sub = dec ? dec_sub : bin_sbc;      // RULE_13
  // Signed overflow from operand and result signs
  wire       ovf_add = (result_r[7] == i_mem_data[7]) &
                       (bin_add[7] != result_r[7]);  // RULE_16
  wire       ovf_sub = (result_r[7] != i_mem_data[7]) &
                       (bin_sub[7] != result_r[7]);  // RULE_16

  // Next value of the working register and condition word
  logic [7:0] result_nxt;
  logic [7:0] cond_nxt;
  logic       chg_zn;
  always_comb begin
    result_nxt = result_r;
    cond_nxt   = cond_r;
    chg_zn     = 1'b0;
    unique case (op)
      crs_pkg::OP_SET_CARRY:  cond_nxt[crs_pkg::FLG_C] = 1'b1; // RULE_19
      crs_pkg::OP_CLR_CARRY:  cond_nxt[crs_pkg::FLG_C] = 1'b0; // RULE_19
      crs_pkg::OP_MASK_IRQ:   cond_nxt[crs_pkg::FLG_I] = 1'b1; // RULE_19
      crs_pkg::OP_UNMASK_IRQ: cond_nxt[crs_pkg::FLG_I] = 1'b0; // RULE_19
      crs_pkg::OP_DEC_ON:     cond_nxt[crs_pkg::FLG_D] = 1'b1; // RULE_19
      crs_pkg::OP_DEC_OFF:    cond_nxt[crs_pkg::FLG_D] = 1'b0; // RULE_19
      crs_pkg::OP_SETT:       cond_nxt[crs_pkg::FLG_T] = 1'b1; // RULE_19
      crs_pkg::OP_DIRECT_OFF: cond_nxt[crs_pkg::FLG_T] = 1'b0; // RULE_19
      crs_pkg::OP_OVF_RESET:  cond_nxt[crs_pkg::FLG_V] = 1'b0; // RULE_19
      crs_pkg::OP_SOFT_BREAK: cond_nxt[crs_pkg::FLG_I] = 1'b1;
      crs_pkg::OP_ADD: begin
        result_nxt = sum_add[7:0];
        cond_nxt[crs_pkg::FLG_C] = sum_add[8];           // RULE_10
        cond_nxt[crs_pkg::FLG_V] = ovf_add;              // RULE_16
        chg_zn = 1'b1;
      end
      crs_pkg::OP_SUB: begin
        result_nxt = sum_sub[7:0];
        cond_nxt[crs_pkg::FLG_C] = sum_sub[8];           // RULE_10
        cond_nxt[crs_pkg::FLG_V] = ovf_sub;              // RULE_16
        chg_zn = 1'b1;
      end
      crs_pkg::OP_BIT: begin
        cond_nxt[crs_pkg::FLG_V] = i_mem_data[6];        // RULE_18
        cond_nxt[crs_pkg::FLG_N] = i_mem_data[7];        // RULE_18
        cond_nxt[crs_pkg::FLG_Z] = (result_r & i_mem_data) == 8'h00;
      end
      crs_pkg::OP_LOAD: begin
        result_nxt = i_mem_data;                         // RULE_01
        chg_zn = 1'b1;
      end
      crs_pkg::OP_SHL: begin
        result_nxt = {result_r[6:0], 1'b0};
        cond_nxt[crs_pkg::FLG_C] = result_r[7];          // RULE_10
        chg_zn = 1'b1;
      end
      crs_pkg::OP_ROR: begin
        result_nxt = {cond_r[crs_pkg::FLG_C], result_r[7:1]};
        cond_nxt[crs_pkg::FLG_C] = result_r[0];          // RULE_10
        chg_zn = 1'b1;
      end
      default: ;
    endcase
    // Zero and negative follow each result; decimal leaves them undefined
    if (chg_zn) begin
      cond_nxt[crs_pkg::FLG_Z] = result_nxt == 8'h00;    // RULE_11 RULE_09
      cond_nxt[crs_pkg::FLG_N] = result_nxt[7];          // RULE_17 RULE_09
    end
    cond_nxt[crs_pkg::FLG_B] = 1'b0;                     // RULE_14
  end

  // Stack traffic: push writes at frame, pop reads at frame plus one
  wire is_push = (op == crs_pkg::OP_PUSH_WORK) |
                 (op == crs_pkg::OP_PUSH_P) |
                 (op == crs_pkg::OP_SOFT_BREAK);         // RULE_20
  wire is_pop  = (op == crs_pkg::OP_POP_WORK) |
                 (op == crs_pkg::OP_POP_P);              // RULE_20
  wire [7:0] push_byte =
    (op == crs_pkg::OP_PUSH_WORK)  ? result_r :
    (op == crs_pkg::OP_SOFT_BREAK) ? (cond_r | 8'h10) :  // RULE_14
                                     cond_r;
  wire is_refused = (op == crs_pkg::OP_FAST_SPEED) |
                    (op == crs_pkg::OP_LOW_SPEED);       // RULE_21

  // Read data selection
  wire [31:0] rd_mux =
    hit_res ? {24'h0, result_r} :
    hit_o1  ? {24'h0, ofs1_r} :
    hit_o2  ? {24'h0, ofs2_r} :
    hit_fr  ? {24'h0, frame_r} :
    hit_fp  ? {16'h0, fetch_hi_r, fetch_lo_r} :         // RULE_06
    hit_cw  ? {24'h0, cond_r} :
    hit_ct  ? {31'h0, page_r} :
    hit_st  ? {30'h0, pop_pend_r, refused_r} :
              32'h0;

  // Bus answer: one cycle after the request, err for unmapped
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ack_r  <= 1'b0;
      err_r  <= 1'b0;
      rdat_r <= 32'h0;
    end else begin
      ack_r  <= req & mapped;
      err_r  <= req & ~mapped;
      rdat_r <= (req & mapped) ? rd_mux : 32'h0;
    end
  end

  // Write strobes, one per register and byte lane
  wire we_res  = wr & hit_res & b0;
  wire we_o1   = wr & hit_o1 & b0;
  wire we_o2   = wr & hit_o2 & b0;
  wire we_fr   = wr & hit_fr & b0;
  wire we_fplo = wr & hit_fp & b0;
  wire we_fphi = wr & hit_fp & b1;
  wire we_cw   = wr & hit_cw & b0;
  wire we_ct   = wr & hit_ct & b0;
  wire clr_ref = wr & hit_st & b0 & i_wb_dat[0];
  // Popped bytes land one cycle after the pop request
  wire pop_w   = pop_pend_r & ~pop_cond_r;
  wire pop_c   = pop_pend_r & pop_cond_r;

  // Working register: popped byte, then bus write, then op result
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      result_r <= crs_pkg::RST_BYTE;
    end else if (pop_w) begin
      result_r <= i_pop_data;                            // RULE_20
    end else if (we_res) begin
      result_r <= i_wb_dat[7:0];                         // RULE_01
    end else begin
      result_r <= result_nxt;
    end
  end

  // Offset registers change only by a bus write
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ofs1_r <= crs_pkg::RST_BYTE;
      ofs2_r <= crs_pkg::RST_BYTE;
    end else begin
      if (we_o1) ofs1_r <= i_wb_dat[7:0];                // RULE_02
      if (we_o2) ofs2_r <= i_wb_dat[7:0];                // RULE_03
    end
  end

  // Condition word; the break bit never lives in the register itself
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cond_r <= crs_pkg::RST_COND;
    end else if (pop_c) begin
      cond_r <= i_pop_data & ~8'h10;                     // RULE_14 RULE_20
    end else if (we_cw) begin
      cond_r <= i_wb_dat[7:0] & ~8'h10;                  // RULE_07
    end else begin
      cond_r <= cond_nxt;
    end
  end

  // Stack page select
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      page_r <= 1'b0;
    end else if (we_ct) begin
      page_r <= i_wb_dat[crs_pkg::CTRL_PAGE];            // RULE_05
    end
  end

  // Frame pointer and stack request; stack ops win over a bus write
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      frame_r    <= crs_pkg::RST_FRAME;
      stack_r    <= '0;
      pop_pend_r <= 1'b0;
      pop_cond_r <= 1'b0;
    end else begin
      stack_r    <= '0;
      pop_pend_r <= is_pop;
      pop_cond_r <= op == crs_pkg::OP_POP_P;
      if (is_push) begin
        stack_r    <= '{push: 1'b1, pop: 1'b0, addr: stk_now,
                        data: push_byte};
        frame_r    <= frame_r - 8'h01;                   // RULE_22
      end else if (is_pop) begin
        stack_r    <= '{push: 1'b0, pop: 1'b1, addr: stk_pop,
                        data: 8'h00};
        frame_r    <= frame_inc;                         // RULE_22
      end else if (we_fr) begin
        frame_r    <= i_wb_dat[7:0];
      end
    end
  end

  // Fetch pointer halves, one byte lane each
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      fetch_hi_r <= crs_pkg::RST_FETCH[15:8];
      fetch_lo_r <= crs_pkg::RST_FETCH[7:0];
    end else begin
      if (we_fplo) fetch_lo_r <= i_wb_dat[7:0];          // RULE_06
      if (we_fphi) fetch_hi_r <= i_wb_dat[15:8];         // RULE_06
    end
  end

  // Sticky refusal flag; write one to clear, a new refusal wins
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      refused_r <= 1'b0;
    end else if (is_refused) begin
      refused_r <= 1'b1;                                 // RULE_21
    end else if (clr_ref) begin
      refused_r <= 1'b0;
    end
  end

  // Outputs
  assign o_wb_dat      = rdat_r;
  assign o_wb_ack      = ack_r;
  assign o_wb_err      = err_r;
  assign o_stack       = stack_r;
  assign o_stack_addr  = stk_now;
  assign o_irq_masked  = cond_r[crs_pkg::FLG_I];         // RULE_12
  assign o_decimal     = cond_r[crs_pkg::FLG_D];         // RULE_13
  assign o_direct_mem  = cond_r[crs_pkg::FLG_T];         // RULE_15
  assign o_branch_cond = {cond_r[crs_pkg::FLG_N], cond_r[crs_pkg::FLG_V],
                          cond_r[crs_pkg::FLG_Z],
                          cond_r[crs_pkg::FLG_C]};       // RULE_08
  assign o_op_refused  = refused_r;

endmodule

// file: verif/crs_core_regs_chk.sv
// Port checker for the core register set
`timescale 1ns/1ps
module crs_core_regs_chk (
  // Clock and reset
  input wire logic                i_clk,
  input wire logic                i_reset,
  // Bus side
  input wire logic                i_wb_cyc,
  input wire logic                i_wb_stb,
  input wire logic                i_wb_we,
  input wire logic [7:0]          i_wb_adr,
  input wire logic                o_wb_ack,
  input wire logic                o_wb_err,
  // Stack and status
  input wire crs_pkg::crs_stack_t o_stack,
  input wire logic [15:0]         o_stack_addr,
  input wire logic                o_irq_masked,
  input wire logic                o_decimal,
  input wire logic                o_direct_mem,
  input wire logic [3:0]          o_branch_cond,
  input wire logic                o_op_refused
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  // A fresh request: strobe rises inside a cycle
  sequence s_req;
    $rose(i_wb_stb) && i_wb_cyc;
  endsequence

  chk_ack_latency: assert property (s_req |=> (o_wb_ack || o_wb_err))
    else $error("no answer one cycle after request");
  chk_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack && !o_wb_err)
    else $error("ack held longer than one cycle");
  chk_err_unmapped: assert property (s_req ##0 (i_wb_adr > 8'h20)
    |=> o_wb_err) else $error("unmapped access not refused");
  chk_stack_page: assert property (o_stack_addr[15:9] == 7'h00)
    else $error("stack high byte outside pages zero and one");
  chk_push_post_dec: assert property (o_stack.push |->
    o_stack_addr == {o_stack.addr[15:8], o_stack.addr[7:0] - 8'h01})
    else $error("push did not post-decrement");
  chk_pop_pre_inc: assert property (o_stack.pop |->
    o_stack_addr == o_stack.addr) else $error("pop did not pre-increment");
  chk_push_pop_excl: assert property (
    !(o_stack.push && o_stack.pop)) else $error("push and pop together");
  // Needs no disable: it looks at the first edge after release
  chk_reset_flags: assert property (disable iff (1'b0)
    $fell(i_reset) |-> o_irq_masked && o_branch_cond == 4'h0
    && !o_decimal && !o_direct_mem) else $error("bad flags after reset");
  chk_flag_cause: assert property (
    $changed({o_branch_cond, o_irq_masked, o_decimal, o_direct_mem})
    |-> $past(i_wb_stb && i_wb_we))
    else $error("flags moved without a write");
  chk_refused_cause: assert property ($rose(o_op_refused) |->
    $past(i_wb_stb && i_wb_we && i_wb_adr == crs_pkg::OFF_OP))
    else $error("refusal without an op write");
endmodule

bind crs_core_regs crs_core_regs_chk i_chk (.i_clk, .i_reset, .i_wb_cyc,
  .i_wb_stb, .i_wb_we, .i_wb_adr, .o_wb_ack, .o_wb_err, .o_stack,
  .o_stack_addr, .o_irq_masked, .o_decimal, .o_direct_mem, .o_branch_cond,
  .o_op_refused);

// file: verif/testbench.sv
// Self-checking bench for the core register set over Wishbone
`timescale 1ns/1ps
module testbench;
  logic                i_clk = 1'b0;
  logic                i_reset = 1'b1;
  logic                cyc = 1'b0;
  logic                stb = 1'b0;
  logic                we = 1'b0;
  logic [7:0]          adr = 8'h00;
  logic [3:0]          sel = 4'h0;
  logic [31:0]         wdat = 32'h0;
  logic [7:0]          mem = 8'h00;
  logic [7:0]          popd = 8'h00;
  logic [31:0]         rdat, o_wb_dat;
  logic                rerr, o_wb_ack, o_wb_err, irq_m, dec, dmem, refused;
  logic [3:0]          brc;
  logic [15:0]         saddr;
  crs_pkg::crs_stack_t stk, o_stack;
  int                  bad_count = 0;
  int                  checks = 0;
  int                  k;
  crs_pkg::crs_op_t    fo [8] = '{crs_pkg::OP_SET_CARRY,
    crs_pkg::OP_MASK_IRQ, crs_pkg::OP_DEC_ON, crs_pkg::OP_SETT,
    crs_pkg::OP_CLR_CARRY, crs_pkg::OP_UNMASK_IRQ, crs_pkg::OP_DEC_OFF,
    crs_pkg::OP_DIRECT_OFF};
  logic [7:0]          fe [8] = '{8'h01, 8'h05, 8'h0d, 8'h2d, 8'h2c, 8'h28,
    8'h20, 8'h00};

  crs_core_regs i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(wdat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .o_wb_err(o_wb_err), .i_mem_data(mem), .i_pop_data(popd),
    .o_stack(o_stack), .o_stack_addr(saddr), .o_irq_masked(irq_m),
    .o_decimal(dec), .o_direct_mem(dmem), .o_branch_cond(brc),
    .o_op_refused(refused));

  // Free-running 100 MHz clock
  always #5 i_clk = ~i_clk;

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One classic cycle; holds until ack or err, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    // No cycle count assumed here; only the watchdog ends a hung wait
    do begin
      @(posedge i_clk);
    end while (o_wb_ack !== 1'b1 && o_wb_err !== 1'b1);
    rdat = o_wb_dat;
    rerr = o_wb_err;
    stk = o_stack;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hf);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hf);
    cmp(rdat & m, e);
  endtask

  task automatic op(input crs_pkg::crs_op_t c);
    wb(1'b1, crs_pkg::OFF_OP, {27'h0, c}, 4'hf);
  endtask

  task automatic end_of_test;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #200000;
    bad_count++;
    end_of_test;
  end

  initial begin
    repeat (20) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    rd(crs_pkg::OFF_RESULT, 32'hff, 32'h00);
    rd(crs_pkg::OFF_FRAME, 32'hff, 32'hff);
    rd(crs_pkg::OFF_COND, 32'hff, 32'h04);
    $display("test reset done");
    wr(crs_pkg::OFF_OFS1, 32'ha5);
    rd(crs_pkg::OFF_OFS1, 32'hff, 32'ha5);
    wr(crs_pkg::OFF_OFS2, 32'h5a);
    rd(crs_pkg::OFF_OFS2, 32'hff, 32'h5a);
    wr(crs_pkg::OFF_FETCH, 32'hbeef);
    wb(1'b1, crs_pkg::OFF_FETCH, 32'h1234, 4'h2);
    rd(crs_pkg::OFF_FETCH, 32'hffff, 32'h12ef);
    wb(1'b0, 8'h40, 32'h0, 4'hf);
    cmp({31'h0, rerr}, 32'h1);
    $display("test registers done");
    wr(crs_pkg::OFF_COND, 32'h00);
    for (k = 0; k < 8; k++) begin
      op(fo[k]);
      rd(crs_pkg::OFF_COND, 32'hff, {24'h0, fe[k]});
      cmp({irq_m, dec, dmem}, {fe[k][2], fe[k][3], fe[k][5]});
    end
    wr(crs_pkg::OFF_COND, 32'hff);
    op(crs_pkg::OP_OVF_RESET);
    rd(crs_pkg::OFF_COND, 32'hff, 32'haf);
    $display("test flags done");
    wr(crs_pkg::OFF_COND, 32'h00);
    wr(crs_pkg::OFF_RESULT, 32'h7f);
    mem <= 8'h01;
    op(crs_pkg::OP_ADD);
    rd(crs_pkg::OFF_RESULT, 32'hff, 32'h80);
    cmp({28'h0, brc}, 32'hc);
    mem <= 8'h80;
    op(crs_pkg::OP_ADD);
    rd(crs_pkg::OFF_COND, 32'hff, 32'h43);
    wr(crs_pkg::OFF_COND, 32'h00);
    mem <= 8'h00;
    op(crs_pkg::OP_LOAD);
    rd(crs_pkg::OFF_COND, 32'hff, 32'h02);
    mem <= 8'hc0;
    op(crs_pkg::OP_BIT);
    rd(crs_pkg::OFF_COND, 32'hc0, 32'hc0);
    wr(crs_pkg::OFF_RESULT, 32'h81);
    op(crs_pkg::OP_SHL);
    rd(crs_pkg::OFF_COND, 32'h01, 32'h01);
    wr(crs_pkg::OFF_COND, 32'h08);
    wr(crs_pkg::OFF_RESULT, 32'h09);
    mem <= 8'h01;
    op(crs_pkg::OP_ADD);
    rd(crs_pkg::OFF_RESULT, 32'hff, 32'h10);
    wr(crs_pkg::OFF_COND, 32'h01);
    wr(crs_pkg::OFF_RESULT, 32'h50);
    mem <= 8'h30;
    op(crs_pkg::OP_SUB);
    rd(crs_pkg::OFF_RESULT, 32'hff, 32'h20);
    rd(crs_pkg::OFF_COND, 32'hff, 32'h01);
    op(crs_pkg::OP_ROR);
    rd(crs_pkg::OFF_RESULT, 32'hff, 32'h90);
    rd(crs_pkg::OFF_COND, 32'hff, 32'h80);
    $display("test arithmetic done");
    wr(crs_pkg::OFF_FRAME, 32'h10);
    wr(crs_pkg::OFF_CTRL, 32'h01);
    cmp({16'h0, saddr}, 32'h0110);
    wr(crs_pkg::OFF_RESULT, 32'h3c);
    op(crs_pkg::OP_PUSH_WORK);
    cmp({6'h0, stk}, {6'h0, 2'b10, 16'h0110, 8'h3c});
    rd(crs_pkg::OFF_FRAME, 32'hff, 32'h0f);
    popd <= 8'h9e;
    op(crs_pkg::OP_POP_WORK);
    cmp({14'h0, stk[25:8]}, {14'h0, 2'b01, 16'h0110});
    rd(crs_pkg::OFF_RESULT, 32'hff, 32'h9e);
    wr(crs_pkg::OFF_CTRL, 32'h00);
    wr(crs_pkg::OFF_COND, 32'h81);
    op(crs_pkg::OP_PUSH_P);
    cmp({6'h0, stk}, {6'h0, 2'b10, 16'h0010, 8'h81});
    op(crs_pkg::OP_SOFT_BREAK);
    cmp({6'h0, stk}, {6'h0, 2'b10, 16'h000f, 8'h91});
    rd(crs_pkg::OFF_COND, 32'hff, 32'h85);
    popd <= 8'hff;
    op(crs_pkg::OP_POP_P);
    rd(crs_pkg::OFF_COND, 32'hff, 32'hef);
    $display("test stack done");
    op(crs_pkg::OP_FAST_SPEED);
    cmp({31'h0, refused}, 32'h1);
    rd(crs_pkg::OFF_STATUS, 32'h01, 32'h01);
    wr(crs_pkg::OFF_STATUS, 32'h01);
    rd(crs_pkg::OFF_STATUS, 32'h01, 32'h00);
    op(crs_pkg::OP_LOW_SPEED);
    rd(crs_pkg::OFF_STATUS, 32'h01, 32'h01);
    $display("test speed ops done");
    end_of_test;
  end
endmodule
